// ===== rtl/sdram_power_defines.vh
`ifndef SDRAM_POWER_DEFINES_VH
`define SDRAM_POWER_DEFINES_VH
// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_ACTIVE 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_BURST_STOP 4'h6
`define CMD_PRECHARGE 4'h2
`define CMD_REFRESH 4'h1
`define CMD_MODE_LOAD 4'h0
// Auto precharge flag and all-bank flag on address bit 10
`define AP_BIT 10
// Mode register field positions
`define MR_BL_LSB 0
`define MR_CL_LSB 4
// Mode register reset value: burst of 4, latency 3
`define MR_RESET 14'h0032
// Timings in cycles at 100 MHz
`define PRECHARGE_CYC 6'h03
`define REFRESH_CYC 6'h0b
`define MODE_LOAD_CYC 6'h02
`define WRITE_RECOVERY_CYC 6'h02
`define EXIT_CYC 6'h02
`define SELF_REFRESH_ENTRY_EXIT_CYC 6'h0c
`endif

// ===== rtl/bank_timer.v
`timescale 1ns/1ps
`default_nettype none
// Per-bank countdown; registered flag shows countdown finished
module bank_timer (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire load,
  input wire [5:0] value,
  output reg done
);
  reg [5:0] count_q;
  // Count down while enabled
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 6'h00;
      done <= 1'b1;
    end else if (ce) begin
      if (load) begin
        count_q <= value;
        done <= (value == 6'h00);
      end else if (count_q != 6'h00) begin
        count_q <= count_q - 6'h01;
        done <= (count_q == 6'h01);
      end
    end
  end
endmodule // bank_timer
`default_nettype wire

// ===== rtl/sdram_power_state.v
// Functional notes
// - Other banks take commands during auto precharge
// - Read auto precharge starts after burst
// - Write auto precharge starts after recovery
// - Both clock enables low hold low-power state
// - Falling enable with no-op enters power-down
// - Falling enable with burst-stop enters deep sleep
// - Falling enable with refresh enters self refresh
// - Rising enable with no-op exits state
// - Accept commands after full initialization
`timescale 1ns/1ps
`default_nettype none
`include "sdram_power_defines.vh"
module sdram_power_state (
  // Clock and reset
  input wire CLK,
  input wire RST,
  input wire CE,
  // Command pins from the controller
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire [1:0] BA,
  input wire [13:0] ADDR,
  // State view
  output reg [2:0] POWER_STATE,
  output reg [3:0] BANK_OPEN,
  output reg [3:0] BANK_PRECHARGING,
  output reg INIT_DONE,
  output reg CMD_ACCEPTED,
  output reg CMD_ILLEGAL
);
  // Power states
  localparam ST_UNINIT = 3'h0;
  localparam ST_NORMAL = 3'h1;
  localparam ST_ACT_PD = 3'h2;
  localparam ST_PRE_PD = 3'h3;
  localparam ST_SELF_REF = 3'h4;
  localparam ST_DEEP = 3'h5;
  localparam ST_EXIT = 3'h6;
  reg [3:0] pins_m_q, pins_q;
  reg [1:0] ba_m_q, ba_q;
  reg [13:0] addr_m_q, addr_q;
  reg cke_m_q, cke_q, cke_prev_q;
  reg [2:0] state_q, state_d;
  reg [3:0] open_q;
  reg [3:0] ap_pend_q;
  reg [5:0] ap_cnt_q [0:3];
  reg [13:0] mode_q;
  reg [2:0] init_q;
  reg [5:0] busy_q;
  reg [5:0] exit_q;
  reg accepted_d, illegal_d;
  wire [3:0] tmr_load;
  wire [3:0] tmr_done;
  wire [3:0] cmd;
  wire [3:0] bank_sel;
  wire all_idle;
  wire cmd_nop;
  wire [5:0] half_burst;
  integer i;
  // Half the burst beats decoded from the mode field
  function [5:0] beats_half;
    input [2:0] code;
    begin
      case (code)
        3'h1: beats_half = 6'h01;
        3'h2: beats_half = 6'h02;
        3'h3: beats_half = 6'h04;
        3'h4: beats_half = 6'h08;
        default: beats_half = 6'h02;
      endcase
    end
  endfunction
  assign cmd = pins_q[3] ? `CMD_NOP : pins_q;
  assign cmd_nop = (cmd == `CMD_NOP);
  assign bank_sel = 4'h1 << ba_q;
  assign all_idle = (open_q == 4'h0) && (ap_pend_q == 4'h0) && (tmr_done == 4'hf);
  assign half_burst = beats_half(mode_q[`MR_BL_LSB+2:`MR_BL_LSB]);
  // Pins cross from the board: two flops before use
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pins_m_q <= 4'hf;
      pins_q <= 4'hf;
      ba_m_q <= 2'h0;
      ba_q <= 2'h0;
      addr_m_q <= 14'h0000;
      addr_q <= 14'h0000;
      cke_m_q <= 1'b0;
      cke_q <= 1'b0;
      cke_prev_q <= 1'b0;
    end else if (CE) begin
      pins_m_q <= {CS_N, RAS_N, CAS_N, WE_N};
      pins_q <= pins_m_q;
      ba_m_q <= BA;
      ba_q <= ba_m_q;
      addr_m_q <= ADDR;
      addr_q <= addr_m_q;
      cke_m_q <= CKE;
      cke_q <= cke_m_q;
      cke_prev_q <= cke_q;
    end
  end
  // Clock-enable truth table
  always @* begin
    state_d = state_q;
    if (!cke_prev_q && !cke_q) begin
      state_d = state_q;
    end else if (!cke_prev_q && cke_q) begin
      if (cmd_nop) begin
        case (state_q)
          ST_ACT_PD: state_d = ST_EXIT;
          ST_PRE_PD: state_d = ST_EXIT;
          ST_SELF_REF: state_d = ST_EXIT;
          ST_DEEP: state_d = ST_UNINIT;
          default: state_d = state_q;
        endcase
      end
    end else if (cke_prev_q && !cke_q && (state_q == ST_NORMAL)) begin
      if (cmd_nop && !all_idle) begin
        state_d = ST_ACT_PD;
      end else if (cmd_nop) begin
        state_d = ST_PRE_PD;
      end else if (all_idle && cmd == `CMD_BURST_STOP) begin
        state_d = ST_DEEP;
      end else if (all_idle && cmd == `CMD_REFRESH) begin
        state_d = ST_SELF_REF;
      end
    end else if (state_q == ST_EXIT && exit_q == 6'h00) begin
      state_d = ST_NORMAL;
    end else if (state_q == ST_UNINIT && init_q == 3'h5 && busy_q == 6'h00) begin
      state_d = ST_NORMAL;
    end
  end
  // Command check in normal operation
  always @* begin
    accepted_d = 1'b0;
    illegal_d = 1'b0;
    if (cke_prev_q && cke_q && !cmd_nop && busy_q == 6'h00) begin
      if (state_q == ST_NORMAL) begin
        case (cmd)
          `CMD_REFRESH, `CMD_MODE_LOAD: illegal_d = !all_idle;
          `CMD_ACTIVE: illegal_d = (open_q & bank_sel) != 4'h0 || !(|(tmr_done & bank_sel));
          `CMD_READ, `CMD_WRITE: illegal_d = (open_q & bank_sel) == 4'h0;
          default: illegal_d = 1'b0;
        endcase
        accepted_d = !illegal_d;
      end else if (state_q == ST_UNINIT) begin
        accepted_d = 1'b1;
      end
    end
  end
  // Auto precharge start: burst end for reads, recovery end for writes
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : bank
      assign tmr_load[g] = (ap_pend_q[g] && ap_cnt_q[g] == 6'h00) ||
        (accepted_d && cmd == `CMD_PRECHARGE && (addr_q[`AP_BIT] || bank_sel[g]));
      bank_timer timer (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .load(tmr_load[g]),
        .value(`PRECHARGE_CYC),
        .done(tmr_done[g])
      );
    end
  endgenerate
  // Bank, mode, init and exit bookkeeping
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_UNINIT;
      open_q <= 4'h0;
      ap_pend_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1) ap_cnt_q[i] <= 6'h00;
      mode_q <= `MR_RESET;
      init_q <= 3'h0;
      busy_q <= 6'h00;
      exit_q <= 6'h00;
      POWER_STATE <= ST_UNINIT;
      BANK_OPEN <= 4'h0;
      BANK_PRECHARGING <= 4'h0;
      INIT_DONE <= 1'b0;
      CMD_ACCEPTED <= 1'b0;
      CMD_ILLEGAL <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      if (busy_q != 6'h00) busy_q <= busy_q - 6'h01;
      if (exit_q != 6'h00) exit_q <= exit_q - 6'h01;
      if (state_d == ST_EXIT && state_q != ST_EXIT) begin
        exit_q <= (state_q == ST_SELF_REF) ? `SELF_REFRESH_ENTRY_EXIT_CYC : `EXIT_CYC;
      end
      // Deep sleep loses everything: init again
      if (state_d == ST_UNINIT && state_q == ST_DEEP) begin
        init_q <= 3'h0;
        mode_q <= `MR_RESET;
        open_q <= 4'h0;
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (ap_pend_q[i]) begin
          if (ap_cnt_q[i] == 6'h00) begin
            ap_pend_q[i] <= 1'b0;
            open_q[i] <= 1'b0;
          end else begin
            ap_cnt_q[i] <= ap_cnt_q[i] - 6'h01;
          end
        end
      end
      if (accepted_d) begin
        case (cmd)
          `CMD_ACTIVE: open_q[ba_q] <= 1'b1;
          `CMD_PRECHARGE: begin
            open_q <= addr_q[`AP_BIT] ? 4'h0 : (open_q & ~bank_sel);
            busy_q <= addr_q[`AP_BIT] ? `PRECHARGE_CYC : 6'h00;
            if (state_q == ST_UNINIT && addr_q[`AP_BIT] && init_q == 3'h0) init_q <= 3'h1;
          end
          `CMD_REFRESH: begin
            busy_q <= `REFRESH_CYC;
            if (state_q == ST_UNINIT && (init_q == 3'h1 || init_q == 3'h2)) init_q <= init_q + 3'h1;
          end
          `CMD_MODE_LOAD: begin
            busy_q <= `MODE_LOAD_CYC;
            if (ba_q == 2'h0) mode_q <= addr_q;
            if (state_q == ST_UNINIT && (init_q == 3'h3 || init_q == 3'h4)) init_q <= init_q + 3'h1;
          end
          `CMD_READ: if (addr_q[`AP_BIT]) begin
            ap_pend_q[ba_q] <= 1'b1;
            ap_cnt_q[ba_q] <= half_burst - 6'h01;
          end
          `CMD_WRITE: if (addr_q[`AP_BIT]) begin
            ap_pend_q[ba_q] <= 1'b1;
            // Recovery counts from the last data beat, not from latency
            ap_cnt_q[ba_q] <= half_burst + `WRITE_RECOVERY_CYC;
          end
          default: ;
        endcase
      end
      POWER_STATE <= state_d;
      BANK_OPEN <= open_q;
      BANK_PRECHARGING <= ~tmr_done | ap_pend_q;
      INIT_DONE <= (state_d != ST_UNINIT) && (state_d != ST_DEEP);
      CMD_ACCEPTED <= accepted_d;
      CMD_ILLEGAL <= illegal_d;
    end
  end
endmodule // sdram_power_state
`default_nettype wire

// ===== bench/pwr_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_power_defines.vh"
module pwr_checker (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Command pins
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  // State view
  input wire [2:0] POWER_STATE,
  input wire [3:0] BANK_OPEN,
  input wire INIT_DONE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Decode at the pins; outputs lag by the two-flop input sync plus the output register
  wire [3:0] cmd = {CS_N, RAS_N, CAS_N, WE_N};
  wire nop = CS_N | (cmd == `CMD_NOP);
  wire up = POWER_STATE == 3'h1;
  wire idle = BANK_OPEN == 4'h0;
  a_pd_entry: assert property (
    $fell(CKE) && nop && up && idle |-> ##[2:4] POWER_STATE == 3'h3) else $error("no precharge power-down");
  a_apd_entry: assert property (
    $fell(CKE) && nop && up && !idle |-> ##[2:4] POWER_STATE == 3'h2) else $error("no active power-down");
  a_deep_entry: assert property (
    $fell(CKE) && cmd == `CMD_BURST_STOP && up && idle |-> ##[2:4] POWER_STATE == 3'h5) else $error("no deep entry");
  a_self_refresh_entry_entry: assert property (
    $fell(CKE) && cmd == `CMD_REFRESH && up && idle |-> ##[2:4] POWER_STATE == 3'h4) else $error("no self refresh");
  a_lp_hold: assert property (
    !CKE && !$past(CKE) && !$past(CKE, 2) && !$past(CKE, 3) && POWER_STATE inside {[3'h2:3'h5]}
    |=> $stable(POWER_STATE)) else $error("low-power state left");
  a_exit_wake: assert property (
    $rose(CKE) && nop && POWER_STATE inside {[3'h2:3'h4]} |-> ##[2:4] POWER_STATE == 3'h6) else $error("no exit");
  a_deep_exit: assert property (
    $rose(CKE) && nop && POWER_STATE == 3'h5 |-> ##[2:20] POWER_STATE == 3'h0) else $error("deep exit not uninit");
  a_uninit_flag: assert property (
    POWER_STATE == 3'h0 |-> !INIT_DONE) else $error("init flag while uninit");
  a_init_ready: assert property (
    $rose(INIT_DONE) |-> ##[0:2] up) else $error("init done but not normal");
  cover property (POWER_STATE == 3'h3);
  cover property (POWER_STATE == 3'h4);
  cover property (POWER_STATE == 3'h5);
endmodule // pwr_checker
bind sdram_power_state pwr_checker u_chk (.CLK(CLK), .RST(RST), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
  .CAS_N(CAS_N), .WE_N(WE_N), .POWER_STATE(POWER_STATE), .BANK_OPEN(BANK_OPEN), .INIT_DONE(INIT_DONE));
`default_nettype wire

// ===== bench/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_power_defines.vh"
module ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output var logic cke,
  output var logic [3:0] cmd,
  output var logic [1:0] ba,
  output var logic [13:0] addr
);
  // Bus starts as no-op with clock enable high
  initial begin
    cke = 1'b1;
    cmd = `CMD_NOP;
    ba = 2'h0;
    addr = 14'h0000;
  end
  // One command on one edge
  task issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, input logic k);
    begin
      @(posedge clk);
      cmd <= c;
      ba <= b;
      addr <= a;
      cke <= k;
    end
  endtask
  // No-op spacing; address toggles since it carries nothing
  task idle(input int n, input logic k);
    int i;
    begin
      for (i = 0; i < n; i++) begin
        @(posedge clk);
        cmd <= `CMD_NOP;
        addr <= ~addr;
        cke <= k;
      end
      #1;
    end
  endtask
  // Power-up sequence with margin on every wait
  task init_seq;
    begin
      idle(20000, 1'b1);
      issue(`CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
      idle(6, 1'b1);
      repeat (2) begin
        issue(`CMD_REFRESH, 2'h0, 14'h0000, 1'b1);
        idle(14, 1'b1);
      end
      issue(`CMD_MODE_LOAD, 2'h0, 14'h0032, 1'b1);
      idle(5, 1'b1);
      issue(`CMD_MODE_LOAD, 2'h2, 14'h0000, 1'b1);
      idle(5, 1'b1);
    end
  endtask
endmodule // ctrl_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_power_defines.vh"
module tb;
  logic clk;
  logic rst;
  wire cke;
  wire [3:0] cmd;
  wire [1:0] ba;
  wire [13:0] addr;
  wire [2:0] state;
  wire [3:0] open_banks;
  wire [3:0] pre_banks;
  wire cmd_ok;
  wire cmd_bad;
  int n_acc = 0;
  int n_ill = 0;
  wire init_done;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  ctrl_model u_ctrl (.clk(clk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr));
  // CE tied high: freezing is not exercised here
  sdram_power_state u_dut (.CLK(clk), .RST(rst), .CE(1'b1), .CKE(cke), .CS_N(cmd[3]), .RAS_N(cmd[2]),
    .CAS_N(cmd[1]), .WE_N(cmd[0]), .BA(ba), .ADDR(addr), .POWER_STATE(state), .BANK_OPEN(open_banks),
    .BANK_PRECHARGING(pre_banks), .INIT_DONE(init_done), .CMD_ACCEPTED(cmd_ok), .CMD_ILLEGAL(cmd_bad));
  // Count answer pulses; each stands for one cycle only
  always @(posedge clk) begin
    if (cmd_ok) n_acc <= n_acc + 1;
    if (cmd_bad) n_ill <= n_ill + 1;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling above the long start-up wait
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report;
    end
  end
  task final_report;
    begin
      $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task check(input logic [3:0] seen, input logic [3:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED at %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Bounded poll, since state lags the pins
  task see(input logic [2:0] s);
    int i;
    begin
      for (i = 0; i < 24 && state !== s; i++) begin
        @(posedge clk);
        #1;
      end
      check({1'b0, state}, {1'b0, s});
    end
  endtask
  task t_init;
    begin
      check({3'h0, init_done}, 4'h0);
      u_ctrl.init_seq;
      see(3'h1);
      check({3'h0, init_done}, 4'h1);
      check(4'(n_acc), 4'h5);
    end
  endtask
  task t_pd;
    begin
      u_ctrl.idle(1, 1'b0);
      see(3'h3);
      u_ctrl.idle(10, 1'b0);
      see(3'h3);
      u_ctrl.idle(1, 1'b1);
      see(3'h6);
      see(3'h1);
    end
  endtask
  task t_apd;
    begin
      u_ctrl.issue(`CMD_ACTIVE, 2'h1, 14'h0123, 1'b1);
      u_ctrl.idle(6, 1'b1);
      check(open_banks, 4'h2);
      u_ctrl.issue(`CMD_REFRESH, 2'h0, 14'h0000, 1'b1);
      u_ctrl.idle(5, 1'b1);
      check(4'(n_ill), 4'h1);
      u_ctrl.idle(1, 1'b0);
      see(3'h2);
      u_ctrl.idle(1, 1'b1);
      see(3'h1);
      u_ctrl.issue(`CMD_WRITE, 2'h1, 14'h0400, 1'b1);
      u_ctrl.issue(`CMD_ACTIVE, 2'h2, 14'h0055, 1'b1);
      u_ctrl.idle(16, 1'b1);
      check(open_banks, 4'h4);
      u_ctrl.issue(`CMD_PRECHARGE, 2'h2, 14'h0000, 1'b1);
      u_ctrl.idle(6, 1'b1);
      check(open_banks, 4'h0);
    end
  endtask
  // Concurrent auto precharge with legal spacing to the other banks
  task t_auto;
    int base;
    begin
      base = n_acc;
      u_ctrl.issue(`CMD_ACTIVE, 2'h0, 14'h0011, 1'b1);
      u_ctrl.issue(`CMD_ACTIVE, 2'h3, 14'h0022, 1'b1);
      u_ctrl.idle(4, 1'b1);
      u_ctrl.issue(`CMD_WRITE, 2'h0, 14'h0400, 1'b1);
      u_ctrl.idle(1, 1'b1);
      u_ctrl.issue(`CMD_WRITE, 2'h3, 14'h0000, 1'b1);
      u_ctrl.idle(8, 1'b1);
      check(open_banks, 4'h8);
      check(pre_banks, 4'h1);
      u_ctrl.issue(`CMD_READ, 2'h3, 14'h0400, 1'b1);
      u_ctrl.issue(`CMD_ACTIVE, 2'h0, 14'h0033, 1'b1);
      u_ctrl.idle(4, 1'b1);
      u_ctrl.issue(`CMD_WRITE, 2'h0, 14'h0000, 1'b1);
      u_ctrl.idle(2, 1'b1);
      check(open_banks, 4'h1);
      u_ctrl.issue(`CMD_PRECHARGE, 2'h0, 14'h0000, 1'b1);
      u_ctrl.idle(6, 1'b1);
      check(open_banks, 4'h0);
      check(4'(n_acc - base), 4'h8);
      check(4'(n_ill), 4'h1);
    end
  endtask
  task t_self_refresh_entry;
    begin
      u_ctrl.issue(`CMD_REFRESH, 2'h0, 14'h0000, 1'b0);
      u_ctrl.idle(4, 1'b0);
      see(3'h4);
      u_ctrl.idle(17, 1'b1);
      see(3'h1);
    end
  endtask
  task t_deep;
    begin
      u_ctrl.issue(`CMD_BURST_STOP, 2'h0, 14'h0000, 1'b0);
      u_ctrl.idle(4, 1'b0);
      see(3'h5);
      u_ctrl.idle(1, 1'b1);
      see(3'h0);
      check({3'h0, init_done}, 4'h0);
    end
  endtask
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_init;
    t_pd;
    t_apd;
    t_auto;
    t_self_refresh_entry;
    t_deep;
    final_report;
  end
endmodule // tb
`default_nettype wire
